// *** hdl/debug_trace_pkg.sv ***
// constants, register map and record types of the debug compare and trace block
// What this block does
// RQ1: hold a 16-bit breakpoint address, used per breakpoint enable and force select
// RQ2: breakpoint address reached only by serial debug commands, never the memory map
// RQ3: force-reset register ignores user writes, serial writes only, reads 0x00
// RQ4: serial write of 1 to force-reset bit 0 starts a full system reset
// RQ5: debug module maps nine bytes: three 16-bit and three 8-bit registers
// RQ6: comparator bytes reset to 0x00, always readable, writable only while not armed
// RQ7: FIFO high port read-only; reads 0x00 in event-only trigger modes
// RQ8: high-port read never advances FIFO; low-port read does; read high first
// RQ9: event-only modes store one data byte per entry, read by low port
// RQ10: host should not read the FIFO while the debugger is armed
// RQ11: unarmed low read pushes last fetched opcode address into last FIFO slot
// RQ12: control register always accessible; enable bit cannot become 1 while secured
// RQ13: arm bit starts a run; run completion or writing arm/enable 0 stops it
// RQ14: control bit 5 picks force (0) or tag (1) breaks; inert without bit 4
// RQ15: bit 4 lets triggers (end trace) or FIFO full (begin trace) request breaks
// RQ16: trigger type select never moves the moment of a break request
// RQ17: bit 2 makes comparator A write-only (bit 3 = 0) or read-only (bit 3 = 1)
// RQ18: bit 0 makes comparator B write-only (bit 1 = 0) or read-only (bit 1 = 1)
// RQ19: run completes on FIFO full (begin trace) or trigger (end trace); arm clears
// RQ20: breakpoint match forces background at boundary if force select, else tags opcode
package debug_trace_pkg;

    // ******************************************************
    // register offsets on the byte-wide register port
    // ******************************************************
    localparam logic [3:0] OFS_CMP_A_HIGH = 4'h0;
    localparam logic [3:0] OFS_CMP_A_LOW = 4'h1;
    localparam logic [3:0] OFS_CMP_B_HIGH = 4'h2;
    localparam logic [3:0] OFS_CMP_B_LOW = 4'h3;
    localparam logic [3:0] OFS_FIFO_HIGH = 4'h4;
    localparam logic [3:0] OFS_FIFO_LOW = 4'h5;
    localparam logic [3:0] OFS_CONTROL = 4'h6;
    localparam logic [3:0] OFS_TRIGGER = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_FORCE_RESET = 4'hF;

    // ******************************************************
    // field positions and reset values
    // ******************************************************
    localparam int CTL_ENABLE = 7;
    localparam int CTL_ARM = 6;
    localparam int CTL_TAG = 5;
    localparam int CTL_BREAK_REQUEST_ENABLE = 4;
    localparam int CTL_RWA = 3;
    localparam int CTL_CMP_A_DIRECTION_ENABLE = 2;
    localparam int CTL_RWB = 1;
    localparam int CTL_CMP_B_DIRECTION_ENABLE = 0;
    localparam int TRG_TYPE_SELECT = 7;
    localparam int TRG_BEGIN = 6;
    localparam int FORCE_RESET_BIT = 0;
    localparam logic [7:0] TRIGGER_WRITE_MASK = 8'hCF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int TRACE_DEPTH = 8;

    // ******************************************************
    // trigger modes and bus sample record
    // ******************************************************
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_B_DATA = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic is_read;
        logic is_fetch;
    } bus_sample_type;

endpackage

// *** hdl/debug_compare_trace_regs.sv ***
// debug compare, trace FIFO, breakpoint and force-reset register logic
`timescale 1ns/1ps
`default_nettype none
module debug_compare_trace_regs
    import debug_trace_pkg::*;
#(
    parameter int DEPTH = TRACE_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic serial_access,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic read_breakpoint_cmd,
    input wire logic write_breakpoint_cmd,
    input wire logic [15:0] breakpoint_wdata,
    output logic [15:0] breakpoint_rdata,
    input wire logic breakpoint_enable,
    input wire logic breakpoint_force_select,
    input wire logic mcu_secure,
    input wire logic cpu_valid,
    output logic cpu_ready,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_data,
    input wire logic cpu_read,
    input wire logic cpu_fetch,
    output logic break_request,
    output logic break_is_tag,
    output logic breakpoint_force_request,
    output logic breakpoint_tag_request,
    output logic system_reset_request,
    output logic run_armed_flag
);

    // ******************************************************
    // state record
    // ******************************************************
    typedef struct packed {
        logic [15:0] breakpoint_match_address;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [7:0] debug_control;
        logic [7:0] trigger;
        logic match_a_flag;
        logic match_b_flag;
        logic started;
        logic [3:0] count;
        logic [DEPTH-1:0][15:0] fifo;
        logic [15:0] last_fetch;
        bus_sample_type [1:0] buffer;
        logic [1:0] buffer_fill;
        logic [7:0] rdata;
        logic [15:0] bkpt_rdata;
        logic reset_req;
        logic brk_req;
        logic brk_tag;
        logic bk_force;
        logic bk_tag;
    } state_type;

    state_type state;
    state_type next_state;

    // ******************************************************
    // combinational decode
    // ******************************************************
    logic armed;
    logic event_mode;
    logic bus_rd;
    logic bus_wr;
    logic take_sample;
    logic drain;
    bus_sample_type sample;
    logic match_a;
    logic match_b;
    logic trig;
    logic complete;
    logic store;
    logic [15:0] store_word;

    assign armed = state.debug_control[CTL_ARM] && state.debug_control[CTL_ENABLE];
    assign event_mode = (state.trigger[3:0] == MODE_EVENT_B)
        || (state.trigger[3:0] == MODE_A_THEN_EVENT_B);
    assign bus_rd = reg_sel && !reg_write;
    assign bus_wr = reg_sel && reg_write;
    // the buffer refuses samples when both slots hold data or the clock is held,
    // so a frozen cycle never swallows a word
    assign cpu_ready = (state.buffer_fill != 2'd2) && clk_en;
    assign take_sample = cpu_valid && cpu_ready;
    // a register access owns the cycle, so tracing stalls and the buffer absorbs it
    assign drain = (state.buffer_fill != 2'd0) && !reg_sel;
    assign sample = state.buffer[0];

    // comparators with optional read/write qualification
    assign match_a = drain && (sample.addr == state.cmp_a)
        && (!state.debug_control[CTL_CMP_A_DIRECTION_ENABLE]
        || (sample.is_read == state.debug_control[CTL_RWA])); // [RQ17]
    assign match_b = drain && (sample.addr == state.cmp_b)
        && (!state.debug_control[CTL_CMP_B_DIRECTION_ENABLE]
        || (sample.is_read == state.debug_control[CTL_RWB])); // [RQ18]

    // trigger condition per mode; tag type needs the opcode actually fetched
    always_comb
    begin
        unique case (state.trigger[3:0])
            MODE_A_ONLY: trig = match_a;
            MODE_A_OR_B: trig = match_a || match_b;
            MODE_A_THEN_B: trig = match_b && state.match_a_flag;
            MODE_EVENT_B: trig = match_b;
            MODE_A_THEN_EVENT_B: trig = match_b && state.match_a_flag;
            MODE_A_AND_B_DATA: trig = match_a && (sample.data == state.cmp_b[7:0]);
            MODE_A_AND_NOT_B_DATA: trig = match_a && (sample.data != state.cmp_b[7:0]);
            MODE_INSIDE: trig = drain && (sample.addr >= state.cmp_a)
                && (sample.addr <= state.cmp_b);
            MODE_OUTSIDE: trig = drain && ((sample.addr < state.cmp_a)
                || (sample.addr > state.cmp_b));
            default: trig = 1'b0;
        endcase
        if (state.trigger[TRG_TYPE_SELECT])
        begin
            trig = trig && sample.is_fetch;
        end
    end

    // storage and completion; break timing hangs only on completion [RQ16]
    always_comb
    begin
        store = 1'b0;
        complete = 1'b0;
        store_word = RESET_WORD;
        if (armed && drain)
        begin
            if (event_mode)
            begin
                store = trig; // [RQ9]
                store_word = {RESET_BYTE, sample.data}; // [RQ7]
                complete = trig && (state.count == 4'(DEPTH - 1)); // [RQ19]
            end
            else if (state.trigger[TRG_BEGIN])
            begin
                store = (state.started || trig) && sample.is_fetch;
                store_word = sample.addr;
                complete = store && (state.count == 4'(DEPTH - 1)); // [RQ19]
            end
            else
            begin
                store = sample.is_fetch;
                store_word = sample.addr;
                complete = trig; // [RQ19]
            end
        end
    end

    // ******************************************************
    // next state
    // ******************************************************
    always_comb
    begin
        logic [7:0] ctl_new;
        ctl_new = RESET_BYTE;
        next_state = state;
        next_state.rdata = state.rdata;
        next_state.reset_req = 1'b0;
        next_state.brk_req = 1'b0;
        next_state.bk_force = 1'b0;
        next_state.bk_tag = 1'b0;

        // two-entry sample buffer: pop slot 0, push behind what remains
        if (drain)
        begin
            next_state.buffer[0] = state.buffer[1];
        end
        unique case ({take_sample, drain})
            2'b10:
            begin
                next_state.buffer[state.buffer_fill[0]] = {cpu_addr, cpu_data, cpu_read, cpu_fetch};
                next_state.buffer_fill = state.buffer_fill + 2'd1;
            end
            2'b01: next_state.buffer_fill = state.buffer_fill - 2'd1;
            2'b11:
            begin
                next_state.buffer[state.buffer_fill[1]] = {cpu_addr, cpu_data, cpu_read, cpu_fetch};
            end
            2'b00: next_state.buffer_fill = state.buffer_fill;
        endcase

        // hardware breakpoint: force at boundary or tag the fetched opcode
        if (drain && breakpoint_enable && (sample.addr == state.breakpoint_match_address))
        begin
            next_state.bk_force = breakpoint_force_select; // [RQ20] [RQ1]
            next_state.bk_tag = !breakpoint_force_select && sample.is_fetch; // [RQ20]
        end
        if (drain && sample.is_fetch)
        begin
            next_state.last_fetch = sample.addr;
        end

        // serial-only breakpoint register access
        if (write_breakpoint_cmd)
        begin
            next_state.breakpoint_match_address = breakpoint_wdata; // [RQ2]
        end
        if (read_breakpoint_cmd)
        begin
            next_state.bkpt_rdata = state.breakpoint_match_address; // [RQ2]
        end

        // run bookkeeping while armed
        if (armed)
        begin
            next_state.match_a_flag = state.match_a_flag || match_a;
            next_state.match_b_flag = state.match_b_flag || match_b;
            next_state.started = state.started || trig;
        end
        if (store)
        begin
            next_state.fifo = {store_word, state.fifo[DEPTH-1:1]};
            if (state.count != 4'(DEPTH))
            begin
                next_state.count = state.count + 4'd1;
            end
        end
        if (complete)
        begin
            next_state.debug_control[CTL_ARM] = 1'b0; // [RQ13] [RQ19]
            next_state.brk_req = state.debug_control[CTL_BREAK_REQUEST_ENABLE]; // [RQ15]
            next_state.brk_tag = state.debug_control[CTL_TAG]; // [RQ14]
        end

        // register reads; the data output is registered
        if (bus_rd)
        begin
            unique case (reg_addr) // [RQ5]
                OFS_CMP_A_HIGH: next_state.rdata = state.cmp_a[15:8]; // [RQ6]
                OFS_CMP_A_LOW: next_state.rdata = state.cmp_a[7:0];
                OFS_CMP_B_HIGH: next_state.rdata = state.cmp_b[15:8];
                OFS_CMP_B_LOW: next_state.rdata = state.cmp_b[7:0];
                OFS_FIFO_HIGH: next_state.rdata = event_mode ? RESET_BYTE
                    : state.fifo[0][15:8]; // [RQ7] [RQ8]
                OFS_FIFO_LOW: next_state.rdata = state.fifo[0][7:0];
                OFS_CONTROL: next_state.rdata = state.debug_control; // [RQ12]
                OFS_TRIGGER: next_state.rdata = state.trigger;
                OFS_STATUS: next_state.rdata = {state.match_a_flag, state.match_b_flag,
                    armed, 1'b0, state.count};
                default: next_state.rdata = RESET_BYTE; // [RQ3]
            endcase
        end
        // low-port read advances only when not armed, refilling the top slot
        if (bus_rd && (reg_addr == OFS_FIFO_LOW) && !armed)
        begin
            next_state.fifo = {state.last_fetch, state.fifo[DEPTH-1:1]}; // [RQ8] [RQ11]
        end

        // register writes; a write lands after any completion this cycle
        if (bus_wr)
        begin
            unique case (reg_addr)
                OFS_CMP_A_HIGH: if (!armed) next_state.cmp_a[15:8] = reg_wdata; // [RQ6]
                OFS_CMP_A_LOW: if (!armed) next_state.cmp_a[7:0] = reg_wdata;
                OFS_CMP_B_HIGH: if (!armed) next_state.cmp_b[15:8] = reg_wdata;
                OFS_CMP_B_LOW: if (!armed) next_state.cmp_b[7:0] = reg_wdata;
                OFS_TRIGGER: if (!armed) next_state.trigger = reg_wdata & TRIGGER_WRITE_MASK;
                OFS_CONTROL:
                begin
                    ctl_new = reg_wdata;
                    ctl_new[CTL_ENABLE] = reg_wdata[CTL_ENABLE] && !mcu_secure; // [RQ12]
                    ctl_new[CTL_ARM] = reg_wdata[CTL_ARM] && ctl_new[CTL_ENABLE]; // [RQ13]
                    next_state.debug_control = ctl_new;
                    if (ctl_new[CTL_ARM] && !armed)
                    begin
                        next_state.match_a_flag = 1'b0;
                        next_state.match_b_flag = 1'b0;
                        next_state.started = 1'b0;
                        next_state.count = 4'd0;
                    end
                end
                OFS_FORCE_RESET:
                begin
                    // user writes are dropped; only the serial path resets the part
                    next_state.reset_req = serial_access
                        && reg_wdata[FORCE_RESET_BIT]; // [RQ3] [RQ4]
                end
                default: next_state.rdata = state.rdata;
            endcase
        end

        // low clock enable freezes everything
        if (!clk_en)
        begin
            next_state = state;
        end
    end

    // ******************************************************
    // state register
    // ******************************************************
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from flops; run_armed_flag is the AND of the enable and arm flops
    assign reg_rdata = state.rdata;
    assign breakpoint_rdata = state.bkpt_rdata;
    assign break_request = state.brk_req;
    assign break_is_tag = state.brk_tag;
    assign breakpoint_force_request = state.bk_force;
    assign breakpoint_tag_request = state.bk_tag;
    assign system_reset_request = state.reset_req;
    assign run_armed_flag = armed;

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking main_clk @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    AST_CMP_LOCKED: assert property (clk_en && armed && bus_wr && (reg_addr <= OFS_CMP_B_LOW)
        |=> $stable(state.cmp_a) && $stable(state.cmp_b)) // [RQ6]
        else $error("comparator changed while armed");
    AST_USER_NO_RESET: assert property (clk_en && bus_wr && (reg_addr == OFS_FORCE_RESET)
        && !serial_access |=> !system_reset_request) // [RQ3]
        else $error("user write caused a reset");
    AST_HOST_RESET: assert property (clk_en && bus_wr && (reg_addr == OFS_FORCE_RESET)
        && serial_access && reg_wdata[0] |=> system_reset_request ##1 !system_reset_request) // [RQ4]
        else $error("serial force reset not a single pulse");
    AST_FORCE_READ_ZERO: assert property (clk_en && bus_rd && (reg_addr == OFS_FORCE_RESET)
        |=> reg_rdata == 8'h00) // [RQ3]
        else $error("force reset register read nonzero");
    AST_SECURE_ENABLE: assert property (clk_en && bus_wr && (reg_addr == OFS_CONTROL)
        && mcu_secure |=> !state.debug_control[CTL_ENABLE] && !run_armed_flag) // [RQ12]
        else $error("enable set while secured");
    AST_HIGH_NO_ADVANCE: assert property (clk_en && bus_rd && (reg_addr == OFS_FIFO_HIGH)
        && !store |=> $stable(state.fifo)) // [RQ8]
        else $error("high read moved the fifo");
    AST_EVENT_HIGH_ZERO: assert property (clk_en && event_mode && bus_rd
        && (reg_addr == OFS_FIFO_HIGH) |=> reg_rdata == 8'h00) // [RQ7]
        else $error("high port nonzero in event mode");
    AST_PROFILE_PUSH: assert property (clk_en && !armed && bus_rd && (reg_addr == OFS_FIFO_LOW)
        |=> state.fifo[DEPTH-1] == $past(state.last_fetch)) // [RQ11]
        else $error("last fetch not pushed on low read");
    AST_BREAK_ENDS_RUN: assert property (break_request |-> $past(state.debug_control[CTL_BREAK_REQUEST_ENABLE])
        && $past(armed) && (!armed || $past(bus_wr))) // [RQ15]
        else $error("break without enable or armed run");
    AST_BREAKPOINT_FORCE: assert property (breakpoint_force_request
        |-> $past(breakpoint_enable) && $past(breakpoint_force_select) && !breakpoint_tag_request) // [RQ20]
        else $error("breakpoint force without enable");

    COV_RUN_COMPLETE: cover property (armed ##[1:200] !armed);
    COV_BREAK_TAG: cover property (break_request && break_is_tag);
    COV_PROFILE_READ: cover property (!armed && bus_rd && (reg_addr == OFS_FIFO_LOW));
    COV_BUFFER_FULL: cover property (cpu_valid && !cpu_ready);

endmodule // debug_compare_trace_regs
`default_nettype wire

// *** dv/cpu_side_model.sv ***
// cpu bus sample source on the far side of the trace block
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model
(
    input wire logic sys_clk,
    input wire logic cpu_ready,
    output logic cpu_valid,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_data,
    output logic cpu_read,
    output logic cpu_fetch
);
    // ********
    // sample driver
    // ********
    initial
    begin
        cpu_valid = 1'b0;
        cpu_addr = 16'h0000;
        cpu_data = 8'h00;
        cpu_read = 1'b0;
        cpu_fetch = 1'b0;
    end
    // hold a sample until a rising edge sees ready; idle fields show the inverse,
    // so a stale value can never pass for a fresh one
    task automatic send(input logic [15:0] a, input logic rd, input logic ft, input int gap);
        repeat (gap) @(negedge sys_clk);
        cpu_valid = 1'b1;
        cpu_addr = a;
        cpu_data = a[7:0];
        cpu_read = rd;
        cpu_fetch = ft;
        do @(posedge sys_clk); while (cpu_ready !== 1'b1);
        @(negedge sys_clk);
        cpu_valid = 1'b0;
        cpu_addr = ~a;
        cpu_data = ~a[7:0];
        cpu_read = ~rd;
        cpu_fetch = ~ft;
    endtask
endmodule // cpu_side_model
`default_nettype wire

// *** dv/debug_compare_trace_regs_bench.sv ***
// self-checking bench of the debug compare and trace register block
`timescale 1ns/1ps
`default_nettype none
module debug_compare_trace_regs_bench import debug_trace_pkg::*;;
    logic sys_clk = 1'b0, reset = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, serial_access = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, cpu_data;
    logic read_breakpoint_cmd = 1'b0, write_breakpoint_cmd = 1'b0, mcu_secure = 1'b0;
    logic breakpoint_enable = 1'b0, breakpoint_force_select = 1'b0;
    logic [15:0] breakpoint_wdata = 16'h0000, breakpoint_rdata, cpu_addr, a_val, b_val, bk, x;
    logic cpu_valid, cpu_ready, cpu_read, cpu_fetch, break_request, break_is_tag;
    logic breakpoint_force_request, breakpoint_tag_request, system_reset_request, run_armed_flag;
    logic due = 1'b0, due_bk = 1'b0, last_tag = 1'b0, clk_en = 1'b1;
    logic [7:0] q[$];
    logic [15:0] qb[$];
    int errors = 0, checked = 0, n_brk = 0, n_frc = 0, n_tag = 0, n_rst = 0, cycles = 0;
    int seed = 74508;
    // run table: control byte, read access, sample at comparator B, break expected
    logic [7:0] t_ctl [7] = '{8'hD0, 8'hF0, 8'hD4, 8'hDC, 8'hDC, 8'hD1, 8'hD3};
    logic [6:0] t_rd = 7'b1110110, t_b = 7'b1100000, t_brk = 7'b1010011;

    debug_compare_trace_regs i_debug_compare_trace_regs (.sys_clk, .reset, .clk_en,
        .reg_sel, .reg_write, .serial_access, .reg_addr, .reg_wdata, .reg_rdata,
        .read_breakpoint_cmd, .write_breakpoint_cmd, .breakpoint_wdata, .breakpoint_rdata,
        .breakpoint_enable, .breakpoint_force_select, .mcu_secure, .cpu_valid, .cpu_ready,
        .cpu_addr, .cpu_data, .cpu_read, .cpu_fetch, .break_request, .break_is_tag,
        .breakpoint_force_request, .breakpoint_tag_request, .system_reset_request,
        .run_armed_flag);
    cpu_side_model i_cpu_side_model (.sys_clk, .cpu_ready, .cpu_valid, .cpu_addr, .cpu_data,
        .cpu_read, .cpu_fetch);

    // ********
    // clock, watchdog, pulse counters and result monitor
    // ********
    always #25 sys_clk = ~sys_clk;
    // pulses stand one cycle, so they are counted at every rising edge
    always @(posedge sys_clk)
    begin
        cycles++;
        n_brk += (break_request === 1'b1);
        n_frc += (breakpoint_force_request === 1'b1);
        n_tag += (breakpoint_tag_request === 1'b1);
        n_rst += (system_reset_request === 1'b1);
        if (break_request === 1'b1) last_tag = break_is_tag;
        if (due) cmp16({8'h00, reg_rdata}, {8'h00, q.pop_front()});
        if (due_bk) cmp16(breakpoint_rdata, qb.pop_front());
        due <= 1'b0;
        due_bk <= 1'b0;
        if (cycles == 3000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    // ********
    // tasks
    // ********
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
        cmp16(got[15:0], exp[15:0]);
    endtask
    task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w, input logic s);
        @(negedge sys_clk);
        reg_sel = 1'b1;
        reg_write = w;
        serial_access = s;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_sel = 1'b0;
        serial_access = 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        access(a, d, 1'b1, 1'b0);
    endtask
    // reads go out as serial commands; a note is queued only when chk is set
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic chk);
        access(a, 8'h00, 1'b0, 1'b1);
        if (chk) q.push_back(e);
        due <= chk;
    endtask
    task automatic bp_cmd(input logic w, input logic [15:0] d);
        @(negedge sys_clk);
        write_breakpoint_cmd = w;
        read_breakpoint_cmd = ~w;
        breakpoint_wdata = d;
        @(negedge sys_clk);
        write_breakpoint_cmd = 1'b0;
        read_breakpoint_cmd = 1'b0;
        if (!w) qb.push_back(d);
        due_bk <= ~w;
    endtask
    task automatic zero_counts;
        repeat (6) @(negedge sys_clk);
        n_brk = 0;
        n_frc = 0;
        n_tag = 0;
        n_rst = 0;
    endtask
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ********
    // main sequence
    // ********
    initial
    begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) rd(i[3:0], RESET_BYTE, 1'b1);
        rd(OFS_FORCE_RESET, 8'h00, 1'b1);
        rd(4'h9, 8'h00, 1'b1);
        $display("end of test 1: reset values");
        a_val = 16'($random(seed));
        b_val = a_val ^ 16'h8000;
        for (int i = 0; i < 4; i++) wr(i[3:0], i < 2 ? a_val[15-8*i -: 8] : b_val[31-8*i -: 8]);
        for (int i = 0; i < 4; i++) rd(i[3:0], i < 2 ? a_val[15-8*i -: 8] : b_val[31-8*i -: 8], 1'b1);
        $display("end of test 2: comparator bytes");
        mcu_secure = 1'b1;
        wr(OFS_CONTROL, 8'h80);
        rd(OFS_CONTROL, 8'h00, 1'b1);
        mcu_secure = 1'b0;
        wr(OFS_CONTROL, 8'h80);
        rd(OFS_CONTROL, 8'h80, 1'b1);
        // a write while the clock enable is low must leave the register alone
        clk_en = 1'b0;
        wr(OFS_CONTROL, 8'h00);
        clk_en = 1'b1;
        rd(OFS_CONTROL, 8'h80, 1'b1);
        $display("end of test 3: secure enable");
        zero_counts();
        wr(OFS_FORCE_RESET, 8'h01);
        access(OFS_FORCE_RESET, 8'h01, 1'b1, 1'b1);
        repeat (6) @(negedge sys_clk);
        cmp_cnt(n_rst, 1);
        $display("end of test 4: force reset");
        bk = 16'($random(seed));
        bp_cmd(1'b1, bk);
        bp_cmd(1'b0, bk);
        breakpoint_enable = 1'b1;
        for (int f = 1; f >= 0; f--)
        begin
            breakpoint_force_select = f[0];
            n_frc = 0;
            n_tag = 0;
            i_cpu_side_model.send(bk, 1'b1, 1'b1, f);
            repeat (6) @(negedge sys_clk);
            cmp_cnt(n_frc + 2 * n_tag, f ? 1 : 2);
        end
        breakpoint_enable = 1'b0;
        $display("end of test 5: breakpoint");
        x = 16'($random(seed));
        i_cpu_side_model.send(x, 1'b1, 1'b1, 2);
        repeat (4) @(negedge sys_clk);
        repeat (8) rd(OFS_FIFO_LOW, 8'h00, 1'b0);
        rd(OFS_FIFO_HIGH, x[15:8], 1'b1);
        rd(OFS_FIFO_HIGH, x[15:8], 1'b1);
        rd(OFS_FIFO_LOW, x[7:0], 1'b1);
        $display("end of test 6: profiling");
        wr(OFS_CONTROL, 8'hC0);
        wr(OFS_CMP_A_HIGH, ~a_val[15:8]);
        rd(OFS_CMP_A_HIGH, a_val[15:8], 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_CONTROL, 8'h80);
            cmp_cnt(run_armed_flag, 0);
            wr(OFS_TRIGGER, t_b[i] ? {4'h0, MODE_A_OR_B} : {4'h0, MODE_A_ONLY});
            wr(OFS_CONTROL, t_ctl[i]);
            cmp_cnt(run_armed_flag, 1);
            zero_counts();
            i_cpu_side_model.send(t_b[i] ? b_val : a_val, t_rd[i], 1'b0, i % 3);
            repeat (6) @(negedge sys_clk);
            cmp_cnt(n_brk, t_brk[i]);
            cmp_cnt(run_armed_flag, !t_brk[i]);
            if (t_brk[i]) cmp_cnt(last_tag, t_ctl[i][CTL_TAG]);
        end
        // event-only B: high port reads zero, one trigger stores one byte
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_TRIGGER, {4'h0, MODE_EVENT_B});
        rd(OFS_FIFO_HIGH, 8'h00, 1'b1);
        wr(OFS_CONTROL, 8'hC0);
        i_cpu_side_model.send(b_val, 1'b1, 1'b0, 0);
        rd(OFS_STATUS, 8'h61, 1'b1);
        $display("end of test 7: armed runs");
        tally_and_finish();
    end
endmodule // debug_compare_trace_regs_bench
`default_nettype wire
